// ---- pkg/erff_consts.svh ----
// Constants of the receive frame filter: register offsets, bit positions,
// reset values and frame-layout figures.
// Assumes inclusion by bare name from the package and design files.
`ifndef ERFF_CONSTS_SVH
`define ERFF_CONSTS_SVH
`define ERFF_OFF_CTRL 8'h00
`define ERFF_OFF_STA0 8'h01
`define ERFF_OFF_MASK0 8'h08
`define ERFF_OFF_WOFF_L 8'h10
`define ERFF_OFF_WOFF_H 8'h11
`define ERFF_OFF_CSUM_L 8'h12
`define ERFF_OFF_CSUM_H 8'h13
`define ERFF_OFF_HASH0 8'h18
`define ERFF_OFF_FCOUNT 8'h20
`define ERFF_OFF_STATUS 8'h21
`define ERFF_CTRL_RESET 8'ha1
`define ERFF_BIT_UNICAST 7
`define ERFF_BIT_COMBINE 6
`define ERFF_BIT_CRC 5
`define ERFF_BIT_PATTERN 4
`define ERFF_BIT_WAKEUP 3
`define ERFF_BIT_HASH 2
`define ERFF_BIT_MCAST 1
`define ERFF_BIT_BCAST 0
`define ERFF_TEST_MASK 8'h9f
`define ERFF_WINDOW_BYTES 16'h0040
`define ERFF_DATA_START 16'h000e
`define ERFF_SYNC_BYTES 3'h6
`define ERFF_ADDR_REPEATS 4'hf
`define ERFF_HASH_LSB 23
`define ERFF_CRC_POLY 32'hedb88320
`define ERFF_FIFO_DEPTH 8
`endif

// ---- pkg/erff_pkg.sv ----
// Types shared by the receive frame filter and its verdict buffer.
// Assumes erff_consts.svh is on the include path.
`default_nettype none
package erff_pkg;
    `include "erff_consts.svh"

    // One byte beat of the incoming frame stream.
    typedef struct packed {
        logic [7:0] data;
        logic sof;
        logic eof;
        logic crc_ok;
    } erff_beat_t;

    // Per-frame verdict handed to the receive buffer logic.
    typedef struct packed {
        logic accept;
        logic crc_ok;
        logic [7:0] passed;
        logic [15:0] length;
    } erff_verdict_t;

    typedef enum logic [1:0] {
        MG_SYNC,
        MG_ADDR,
        MG_DONE
    } erff_wake_state_t;
endpackage : erff_pkg
`default_nettype wire

// ---- src/erff_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`default_nettype none
module erff_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] level_reg;
    logic push;
    logic pop;

    // Full and empty come straight from the fill level.
    assign in_ready = (level_reg != DEPTH[AW:0]);
    assign out_valid = (level_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg];

    // Storage array has no reset; only valid entries are ever read.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers wrap; depth is expected to be a power of two.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            level_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                level_reg <= level_reg + 1'b1;
            end else if (pop && !push) begin
                level_reg <= level_reg - 1'b1;
            end
        end
    end
endmodule : erff_fifo
`default_nettype wire

// ---- src/erff_filter.sv ----
// Receive frame filter: runs every enabled test over each incoming frame
// and queues one verdict per accepted frame into an 8-entry FIFO.
// Assumes a byte stream from the MAC receive path, with the CRC status
// valid on the last beat, and a simple strobe register port.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`default_nettype none
`include "erff_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Combine bit 1: reject unless every enabled test accepts.
// - Combine bit 0: accept unless every enabled test rejects.
// - Tests may run together; disabled tests take no part.
// - All enables cleared gives promiscuous reception of every frame, bad-CRC frames excepted while the CRC check bit is set.
// - Unicast test passes when destination equals station address, six bytes.
// - CRC check bit set discards bad-CRC frames; clear ignores CRC.
// - Pattern test checksums up to 64 window bytes against expected value.
// - Window starts at offset from first destination byte; mask bit per byte.
// - Masked-out bytes are skipped entirely, not summed as zeros.
// - Window running past the CRC end fails the pattern test.
// - Checksum is the ones-complement IP sum used by the DMA engine.
// - Wake-up test: own address, six FF bytes, sixteen address copies.
// - Hash test indexes the table with a destination-address CRC.
// - Multicast test passes when first destination byte bit 0 is set.
// - Broadcast test passes when destination is all ones.
module erff_filter
    import erff_pkg::*;
#(
    parameter int FIFO_DEPTH = `ERFF_FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Frame stream from the MAC receive path.
    input wire logic rx_valid,
    output logic rx_ready,
    input wire erff_beat_t rx_beat,
    // Verdicts of accepted frames towards the receive buffer.
    output logic vd_valid,
    input wire logic vd_ready,
    output erff_verdict_t vd_data
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers and frame state.
    logic [7:0] rx_filter_control_reg;
    logic [7:0] sta_reg [6];
    logic [63:0] mask_reg;
    logic [15:0] woff_reg;
    logic [15:0] pattern_expected_checksum_reg;
    logic [63:0] hash_table_bits_reg;
    logic [7:0] fcount_reg;
    logic [7:0] status_reg;
    logic [7:0] rdata_reg;
    logic [7:0] da_reg [6];
    logic [15:0] pos_reg;
    logic [15:0] pos_now;
    logic [31:0] crc_reg;
    logic [15:0] csum_reg;
    logic [7:0] csum_hi_reg;
    logic csum_odd_reg;
    erff_wake_state_t wk_state_reg;
    logic [2:0] ff_run_reg;
    logic [2:0] wk_idx_reg;
    logic [3:0] wk_rep_reg;
    logic eval_reg;
    logic crc_ok_reg;
    logic beat;
    logic in_window;
    logic [15:0] win_idx;
    logic fifo_in_ready;
    logic fifo_push;
    logic [7:0] pass;
    logic [7:0] enabled;
    logic accept;
    logic [15:0] csum_final;
    logic [5:0] hash_idx;
    logic uc_hit;
    logic bc_hit;
    erff_verdict_t verdict;

    // Ones-complement 16-bit add with end-around carry.
    function automatic logic [15:0] ones_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0000, s[16]};
    endfunction : ones_add

    // Reflected CRC-32 over one byte, no final inversion.
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = ((r[0] ^ d[i]) != 1'b0) ? ((r >> 1) ^ `ERFF_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_byte

    ////////////////////////////////////////////////////////////////////////////
    // Stream handshake. The stream stalls while the verdict of the previous
    // frame is queued or the FIFO is full, so back-pressure reaches the MAC.
    assign rx_ready = fifo_in_ready && !eval_reg;
    assign beat = rx_valid && rx_ready;
    assign pos_now = rx_beat.sof ? 16'h0000 : pos_reg;
    assign win_idx = pos_now - woff_reg;
    assign in_window = (pos_now >= woff_reg) && (win_idx < `ERFF_WINDOW_BYTES);

    // Byte position within the frame, saturating for oversize frames.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pos_reg <= 16'h0000;
        end else if (beat && pos_now != 16'hffff) begin
            pos_reg <= pos_now + 16'h0001;
        end
    end

    // Destination capture and hash CRC over the first six bytes.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 6; i++) begin
                da_reg[i] <= 8'h00;
            end
            crc_reg <= 32'hffffffff;
        end else if (beat && pos_now < 16'h0006) begin
            da_reg[pos_now[2:0]] <= rx_beat.data;
            crc_reg <= crc_byte(rx_beat.sof ? 32'hffffffff : crc_reg, rx_beat.data);
        end
    end

    // Pattern checksum: included bytes pair high then low; skipped bytes do
    // not shift the pairing, which is what distinguishes them from zeros.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            csum_reg <= 16'h0000;
            csum_hi_reg <= 8'h00;
            csum_odd_reg <= 1'b0;
        end else if (beat) begin
            if (in_window && mask_reg[win_idx[5:0]]) begin
                csum_odd_reg <= !(csum_odd_reg && !rx_beat.sof);
                if (csum_odd_reg && !rx_beat.sof) begin
                    csum_reg <= ones_add(csum_reg, {csum_hi_reg, rx_beat.data});
                end else begin
                    csum_hi_reg <= rx_beat.data;
                    if (rx_beat.sof) begin
                        csum_reg <= 16'h0000;
                    end
                end
            end else if (rx_beat.sof) begin
                csum_reg <= 16'h0000;
                csum_odd_reg <= 1'b0;
            end
        end
    end

    // Wake-up frame search through the data field.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wk_state_reg <= MG_SYNC;
            ff_run_reg <= 3'h0;
            wk_idx_reg <= 3'h0;
            wk_rep_reg <= 4'h0;
        end else if (beat) begin
            if (rx_beat.sof) begin
                wk_state_reg <= MG_SYNC;
                ff_run_reg <= 3'h0;
            end else if (pos_now >= `ERFF_DATA_START) begin
                case (wk_state_reg)
                    MG_SYNC: begin
                        if (rx_beat.data == 8'hff) begin
                            if (ff_run_reg != `ERFF_SYNC_BYTES) begin
                                ff_run_reg <= ff_run_reg + 3'h1;
                            end
                        end else begin
                            ff_run_reg <= 3'h0;
                            if (ff_run_reg == `ERFF_SYNC_BYTES && rx_beat.data == sta_reg[0]) begin
                                wk_state_reg <= MG_ADDR;
                                wk_idx_reg <= 3'h1;
                                wk_rep_reg <= 4'h0;
                            end
                        end
                    end
                    MG_ADDR: begin
                        if (rx_beat.data == sta_reg[wk_idx_reg]) begin
                            if (wk_idx_reg == 3'h5) begin
                                wk_idx_reg <= 3'h0;
                                wk_rep_reg <= wk_rep_reg + 4'h1;
                                if (wk_rep_reg == `ERFF_ADDR_REPEATS) begin
                                    wk_state_reg <= MG_DONE;
                                end
                            end else begin
                                wk_idx_reg <= wk_idx_reg + 3'h1;
                            end
                        end else begin
                            // A broken run may itself start a new sync run.
                            wk_state_reg <= MG_SYNC;
                            ff_run_reg <= (rx_beat.data == 8'hff) ? 3'h1 : 3'h0;
                        end
                    end
                    MG_DONE: begin
                        wk_state_reg <= MG_DONE;
                    end
                    default: begin
                        wk_state_reg <= MG_SYNC;
                    end
                endcase
            end
        end
    end

    // Evaluation is taken one cycle after the last beat.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            eval_reg <= 1'b0;
            crc_ok_reg <= 1'b0;
        end else begin
            eval_reg <= beat && rx_beat.eof;
            if (beat && rx_beat.eof) begin
                crc_ok_reg <= rx_beat.crc_ok;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test results and combined decision.
    assign csum_final = ~(csum_odd_reg ? ones_add(csum_reg, {csum_hi_reg, 8'h00}) : csum_reg);
    assign hash_idx = crc_reg[`ERFF_HASH_LSB +: 6];
    always_comb begin
        uc_hit = 1'b1;
        bc_hit = 1'b1;
        for (int i = 0; i < 6; i++) begin
            uc_hit = uc_hit && (da_reg[i] == sta_reg[i]);
            bc_hit = bc_hit && (da_reg[i] == 8'hff);
        end
        pass = 8'h00;
        pass[`ERFF_BIT_UNICAST] = uc_hit;
        // The sum is one bit wider so that a large offset cannot wrap round and pass a short frame.
        pass[`ERFF_BIT_PATTERN] = ({1'b0, pos_reg} >= {1'b0, woff_reg} + 17'(`ERFF_WINDOW_BYTES))
            && (csum_final == pattern_expected_checksum_reg);
        pass[`ERFF_BIT_WAKEUP] = uc_hit && (wk_state_reg == MG_DONE);
        pass[`ERFF_BIT_HASH] = hash_table_bits_reg[hash_idx];
        pass[`ERFF_BIT_MCAST] = da_reg[0][0];
        pass[`ERFF_BIT_BCAST] = bc_hit;
        enabled = rx_filter_control_reg & `ERFF_TEST_MASK;
        if (enabled == 8'h00) begin
            accept = 1'b1;
        end else if (rx_filter_control_reg[`ERFF_BIT_COMBINE]) begin
            accept = ((pass | ~enabled) == 8'hff);
        end else begin
            accept = ((pass & enabled) != 8'h00);
        end
        if (rx_filter_control_reg[`ERFF_BIT_CRC] && !crc_ok_reg) begin
            accept = 1'b0;
        end
    end

    // Only accepted frames are queued; rejected frames vanish here.
    assign verdict = '{accept: accept, crc_ok: crc_ok_reg, passed: pass, length: pos_reg};
    assign fifo_push = eval_reg && accept;

    erff_fifo #(
        .WIDTH($bits(erff_verdict_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(verdict),
        .out_valid(vd_valid),
        .out_ready(vd_ready),
        .out_data(vd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register writes; the host must load the pattern setup before enabling it.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_filter_control_reg <= `ERFF_CTRL_RESET;
            for (int i = 0; i < 6; i++) begin
                sta_reg[i] <= 8'h00;
            end
            mask_reg <= 64'h0;
            woff_reg <= 16'h0000;
            pattern_expected_checksum_reg <= 16'h0000;
            hash_table_bits_reg <= 64'h0;
        end else if (reg_wr) begin
            if (reg_addr == `ERFF_OFF_CTRL) begin
                rx_filter_control_reg <= reg_wdata;
            end
            if (reg_addr >= `ERFF_OFF_STA0 && reg_addr < `ERFF_OFF_STA0 + 8'h06) begin
                sta_reg[3'(reg_addr - `ERFF_OFF_STA0)] <= reg_wdata;
            end
            if (reg_addr[7:3] == `ERFF_OFF_MASK0 >> 3) begin
                mask_reg[reg_addr[2:0]*8 +: 8] <= reg_wdata;
            end
            if (reg_addr[7:3] == `ERFF_OFF_HASH0 >> 3) begin
                hash_table_bits_reg[reg_addr[2:0]*8 +: 8] <= reg_wdata;
            end
            if (reg_addr == `ERFF_OFF_WOFF_L) woff_reg[7:0] <= reg_wdata;
            if (reg_addr == `ERFF_OFF_WOFF_H) woff_reg[15:8] <= reg_wdata;
            if (reg_addr == `ERFF_OFF_CSUM_L) pattern_expected_checksum_reg[7:0] <= reg_wdata;
            if (reg_addr == `ERFF_OFF_CSUM_H) pattern_expected_checksum_reg[15:8] <= reg_wdata;
        end
    end

    // Accepted-frame count saturates; status keeps the last verdict.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fcount_reg <= 8'h00;
            status_reg <= 8'h00;
        end else if (eval_reg) begin
            status_reg <= {6'h00, crc_ok_reg, accept};
            if (accept && fcount_reg != 8'hff) begin
                fcount_reg <= fcount_reg + 8'h01;
            end
        end
    end

    // Read data stands for exactly one cycle after the strobe.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 8'h00;
        end else if (!reg_rd) begin
            rdata_reg <= 8'h00;
        end else begin
            case (reg_addr)
                `ERFF_OFF_CTRL: rdata_reg <= rx_filter_control_reg;
                `ERFF_OFF_WOFF_L: rdata_reg <= woff_reg[7:0];
                `ERFF_OFF_WOFF_H: rdata_reg <= woff_reg[15:8];
                `ERFF_OFF_CSUM_L: rdata_reg <= pattern_expected_checksum_reg[7:0];
                `ERFF_OFF_CSUM_H: rdata_reg <= pattern_expected_checksum_reg[15:8];
                `ERFF_OFF_FCOUNT: rdata_reg <= fcount_reg;
                `ERFF_OFF_STATUS: rdata_reg <= status_reg;
                default: begin
                    if (reg_addr >= `ERFF_OFF_STA0 && reg_addr < `ERFF_OFF_STA0 + 8'h06) begin
                        rdata_reg <= sta_reg[3'(reg_addr - `ERFF_OFF_STA0)];
                    end else if (reg_addr[7:3] == `ERFF_OFF_MASK0 >> 3) begin
                        rdata_reg <= mask_reg[reg_addr[2:0]*8 +: 8];
                    end else if (reg_addr[7:3] == `ERFF_OFF_HASH0 >> 3) begin
                        rdata_reg <= hash_table_bits_reg[reg_addr[2:0]*8 +: 8];
                    end else begin
                        rdata_reg <= 8'h00;
                    end
                end
            endcase
        end
    end
    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_and_reject: assert property (@(posedge sys_clk) disable iff (!arst_n)
        eval_reg && rx_filter_control_reg[6] && ((enabled & ~pass) != 8'h00) |-> !fifo_push)
        else $error("AND mode queued a frame failing an enabled test");
    a_or_accept: assert property (@(posedge sys_clk) disable iff (!arst_n)
        eval_reg && !rx_filter_control_reg[6] && ((enabled & pass) != 8'h00)
        && !(rx_filter_control_reg[5] && !crc_ok_reg) |-> fifo_push)
        else $error("OR mode dropped a frame passing an enabled test");
    a_promisc_keep: assert property (@(posedge sys_clk) disable iff (!arst_n)
        eval_reg && rx_filter_control_reg == 8'h00 |-> fifo_push)
        else $error("Promiscuous mode dropped a frame");
    a_crc_discard: assert property (@(posedge sys_clk) disable iff (!arst_n)
        beat && rx_beat.eof && !rx_beat.crc_ok && rx_filter_control_reg[5] ##1 eval_reg |-> !fifo_push)
        else $error("Bad-CRC frame queued with CRC check on");
    a_window_short: assert property (@(posedge sys_clk) disable iff (!arst_n)
        eval_reg && {1'b0, pos_reg} < {1'b0, woff_reg} + 17'h00040 |-> !pass[4])
        else $error("Pattern test passed with window past frame end");
    a_mcast_bit: assert property (@(posedge sys_clk) disable iff (!arst_n)
        beat && rx_beat.sof ##1 (!eval_reg)[*1] |-> pass[1] == $past(rx_beat.data[0]))
        else $error("Multicast test disagrees with first address bit");
    a_hash_lookup: assert property (@(posedge sys_clk) disable iff (!arst_n)
        eval_reg && hash_table_bits_reg == 64'h0 |-> !pass[2])
        else $error("Hash test passed with empty table");
    a_reject_count: assert property (@(posedge sys_clk) disable iff (!arst_n)
        eval_reg && !accept |=> $stable(fcount_reg))
        else $error("Rejected frame changed the frame count");
    a_eof_verdict: assert property (@(posedge sys_clk) disable iff (!arst_n)
        beat && rx_beat.eof |=> eval_reg ##1 !eval_reg)
        else $error("Verdict not taken one cycle after frame end");
endmodule : erff_filter
`default_nettype wire

// ---- test/erff_rx_mac.sv ----
// Behavioural MAC receive path: streams one queued frame with random stalls.
// Assumes the filter's rx_ready and one shared clock.
`default_nettype none
module erff_rx_mac (
    // Clock.
    input wire logic sys_clk,
    // Byte stream into the filter.
    output logic rx_valid,
    input wire logic rx_ready,
    output erff_pkg::erff_beat_t rx_beat
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] frame [$];
    integer seed = 32'h5b91e476;
    initial begin
        rx_valid = 1'b0;
        rx_beat = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Each beat is held until taken; idle beats carry inverted data so a stale byte never looks valid.
    task automatic send(input logic good);
        for (int i = 0; i < frame.size(); i++) begin
            if (($random(seed) & 3) == 0) begin
                rx_valid <= 1'b0;
                rx_beat.data <= ~rx_beat.data;
                @(posedge sys_clk);
            end
            rx_valid <= 1'b1;
            rx_beat <= '{frame[i], i == 0, i == frame.size() - 1, good};
            do @(posedge sys_clk); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
        rx_beat.data <= ~frame[frame.size() - 1];
        // One idle edge, so the next frame never drives the same signals in this time step.
        @(posedge sys_clk);
    endtask : send
endmodule : erff_rx_mac
`default_nettype wire

// ---- test/ethernet_rx_frame_filter_tb.sv ----
// Self-checking bench for the receive frame filter.
// Assumes erff_rx_mac as the stream source and a 40 MHz clock.
`default_nettype none
module ethernet_rx_frame_filter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, rd_d, rx_valid, rx_ready, vd_valid, vd_ready, hold;
    erff_pkg::erff_beat_t rx_beat;
    erff_pkg::erff_verdict_t vd_data;
    logic [7:0] rd_exp [$];
    logic [16:0] vd_exp [$];
    int miscompares, tests_run, cycles, count;
    integer seed = 32'h5b91e476;
    logic [47:0] sta;
    logic wake;
    always #12.5 sys_clk = ~sys_clk;
    erff_filter #(.FIFO_DEPTH(8)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_beat(rx_beat), .vd_valid(vd_valid), .vd_ready(vd_ready), .vd_data(vd_data));
    erff_rx_mac mac (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_beat(rx_beat));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    // Strobes drop with an idle edge after them, so no signal is driven twice in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_exp.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
    endtask : rd
    task automatic frame(input logic [47:0] da, input int len, input logic good, input logic acc);
        mac.frame.delete();
        for (int i = 0; i < len; i++) begin
            if (i < 6) mac.frame.push_back(da[47-8*i -: 8]);
            else if (wake && i >= 14 && i < 20) mac.frame.push_back(8'hff);
            else if (wake && i >= 20 && i < 116) mac.frame.push_back(sta[47-8*((i-20)%6) -: 8]);
            else mac.frame.push_back(8'($random(seed)));
        end
        if (acc) begin
            vd_exp.push_back({good, len[15:0]});
            count++;
        end
        mac.send(good);
    endtask : frame
    ////////////////////////////////////////////////////////////////////////////
    // Read data and verdicts are compared against the oldest note; the drain side stalls at random.
    always @(posedge sys_clk) begin
        rd_d <= reg_rd;
        vd_ready <= !hold && ($random(seed) & 1);
        cycles++;
        if (rd_d) check({24'h0, reg_rdata}, {24'h0, rd_exp.pop_front()});
        if (vd_valid && vd_ready && vd_exp.size() == 0) check(32'h1, 32'h0);
        else if (vd_valid && vd_ready) check({vd_data.accept, vd_data.crc_ok, vd_data.length}, {1'b1, vd_exp.pop_front()});
        if (cycles == 30000) begin
            miscompares++;
            end_sim;
        end
    end
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, wake, hold} = '0;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        rd(8'h00, 8'ha1);
        rd(8'h30, 8'h00);
        sta = {8'h02, 8'($random(seed)), 32'($random(seed))};
        for (int i = 0; i < 6; i++) wr(8'h01 + i[7:0], sta[47-8*i -: 8]);
        frame(sta, 64, 1, 1);
        frame(48'hffffffffffff, 60, 1, 1);
        frame(sta ^ 48'h1, 60, 1, 0);
        frame(sta, 64, 0, 0);
        wr(8'h00, 8'h00);
        frame(48'h0a0b0c0d0e0f, 64, 0, 1);
        wr(8'h00, 8'hc3);
        frame(48'hffffffffffff, 64, 1, 0);
        wr(8'h00, 8'h42);
        frame(48'h030000000001, 64, 1, 1);
        frame(48'h020000000001, 64, 1, 0);
        wr(8'h00, 8'h04);
        for (int i = 0; i < 8; i++) wr(8'h18 + i[7:0], 8'hff);
        frame(sta ^ 48'h5, 64, 1, 1);
        for (int i = 0; i < 8; i++) wr(8'h18 + i[7:0], 8'h00);
        frame(sta ^ 48'h5, 64, 1, 0);
        wr(8'h08, 8'h05);
        wr(8'h12, 8'hcb);
        wr(8'h13, 8'hed);
        wr(8'h00, 8'h10);
        rd(8'h13, 8'hed);
        frame(48'h12ff34000000, 64, 1, 1);
        frame(48'h12ff34000000, 63, 1, 0);
        frame(48'h12ff35000000, 64, 1, 0);
        // Wake-up test alone: full pattern, cut pattern, and foreign destination.
        wr(8'h00, 8'h08);
        wake = 1'b1;
        frame(sta, 128, 1, 1);
        frame(sta, 110, 1, 0);
        frame(sta ^ 48'h0100, 128, 1, 0);
        wake = 1'b0;
        wr(8'h00, 8'h00);
        hold <= 1'b1;
        repeat (8) frame(48'h020000000001, 64, 1, 1);
        fork
            frame(48'h020000000001, 64, 1, 1);
            begin
                repeat (200) @(posedge sys_clk);
                check({31'h0, rx_ready}, 32'h0);
                hold <= 1'b0;
            end
        join
        repeat (100) @(posedge sys_clk);
        rd(8'h20, count[7:0]);
        rd(8'h21, 8'h03);
        check(vd_exp.size(), 32'h0);
        end_sim;
    end
endmodule : ethernet_rx_frame_filter_tb
`default_nettype wire
